// *** rtl/twu_pkg.sv ***
package twu_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] ADDR_EIVR   = 8'hF6;
    localparam logic [7:0] ADDR_CNT_HI = 8'hF8;
    localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
    localparam logic [7:0] ADDR_PSC    = 8'hFA;
    localparam logic [7:0] ADDR_CTRL   = 8'hFB;
    localparam logic [7:0] ADDR_WCR    = 8'hFC;

    // =========================================================
    // Field positions and reset values
    localparam int         WCR_WATCHDOG_ENABLE_N_POS = 6;
    localparam int         EIVR_TLIS_POS = 2;
    localparam int         EIVR_IA0S_POS = 1;
    localparam logic [15:0] RST_CNT      = 16'hFFFF;
    localparam logic [7:0]  RST_PSC      = 8'hFF;
    localparam logic [7:0]  RST_CTRL     = 8'h12;
    localparam logic        RST_TLIS     = 1'h1;
    localparam logic        RST_IA0S     = 1'h1;

    // =========================================================
    // Watchdog key and timing counts
    localparam logic [7:0] KEY_FIRST    = 8'hAA;
    localparam logic [7:0] KEY_SECOND   = 8'h55;
    localparam int         INTERNAL_CLOCK_DIV   = 4;
    localparam logic [1:0] DIV_LAST     = 2'(INTERNAL_CLOCK_DIV - 1);
    localparam int         EVENT_MIN_GAP = 8;

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        TWU_IN_EVENT  = 2'b00,
        TWU_IN_GATED  = 2'b01,
        TWU_IN_TRIG   = 2'b10,
        TWU_IN_RETRIG = 2'b11
    } twu_inmode_type;

    typedef struct packed {
        logic           run;
        logic           single;
        twu_inmode_type inmd;
        logic           input_en;
        logic           out_mode;
        logic           pwm_level;
        logic           out_en;
    } twu_ctrl_type;

endpackage

// *** rtl/twu_top.sv ***
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module twu_top
(
    input  wire logic       mclk_i,                   // Internal clock
    input  wire logic       rst_n_i,                  // External reset, active low
    input  wire logic [7:0] addr_i,                   // Register address
    input  wire logic [7:0] wdata_i,                  // Write data
    input  wire logic       wr_i,                     // Write strobe
    input  wire logic       rd_i,                     // Read strobe
    output logic      [7:0] rdata_o,                  // Read data, cycle after strobe
    input  wire logic       timer_input_pin_i,        // Timer input pin
    input  wire logic       hw_watchdog_select_pin_i, // Low selects hardware watchdog
    input  wire logic       external_interrupt_zero_i,// External interrupt 0 pin
    input  wire logic       nmi_i,                    // Non-maskable interrupt pin
    output logic            timer_output_pin_o,       // Timer output pin
    output logic            sys_reset_o,              // Watchdog system reset pulse
    output logic            top_irq_o,                // Top level interrupt request
    output logic            inta0_irq_o               // Channel A0 interrupt request
);

    // =========================================================
    // Reset release and pin synchronisers
    logic       rst_m_q;
    logic       rst_n;
    logic [3:0] pin_m_q;
    logic [3:0] pin_s_q;
    logic       tin_prev_q;

    // Reset is asserted at once and released through two flops
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // Two flops for every pin; a third flop for the edge detector
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m_q    <= 4'hF;
            pin_s_q    <= 4'hF;
            tin_prev_q <= 1'b1;
        end
        else
        begin
            pin_m_q    <= {nmi_i, external_interrupt_zero_i, hw_watchdog_select_pin_i, timer_input_pin_i};
            pin_s_q    <= pin_m_q;
            tin_prev_q <= pin_s_q[0];
        end
    end

    logic tin_s;
    logic tin_fall;
    logic hwsel_s;
    logic external_interrupt_zero_s;
    logic nmi_s;
    assign tin_s    = pin_s_q[0];
    assign tin_fall = tin_prev_q & ~pin_s_q[0];
    assign hwsel_s  = pin_s_q[1];
    assign external_interrupt_zero_s   = pin_s_q[2];
    assign nmi_s    = pin_s_q[3];

    // =========================================================
    // Timer state
    twu_pkg::twu_ctrl_type ctrl_q, ctrl_d;
    logic [15:0] const_q, const_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0]  pr_q, pr_d;
    logic [7:0]  psc_q, psc_d;
    logic [1:0]  div_q, div_d;
    logic        new_const_q, new_const_d;
    logic        trig_q, trig_d;
    logic        wd_q, wd_d;
    logic        watchdog_enable_n_n_q, watchdog_enable_n_n_d;
    logic        key_q, key_d;
    logic [1:0]  strap_q, strap_d;
    logic        tlis_q, tlis_d;
    logic        ia0s_q, ia0s_d;
    logic        out_q, out_d;
    logic        srst_q, srst_d;
    logic        top_q, top_d;
    logic        a0_q, a0_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        cnt_en;
    logic        ctick;
    logic        eoc;
    logic        wr_lo;
    logic        wr_ctrl;
    logic        retrig;

    // Count enable ahead of the prescaler
    always_comb
    begin
        cnt_en = 1'b0;
        if (wd_q)
            cnt_en = (div_q == twu_pkg::DIV_LAST);
        else if (ctrl_q.run)
        begin
            if (!ctrl_q.input_en)
                cnt_en = (div_q == twu_pkg::DIV_LAST);
            else
            begin
                case (ctrl_q.inmd)
                    twu_pkg::TWU_IN_EVENT:  cnt_en = tin_fall;
                    twu_pkg::TWU_IN_GATED:  cnt_en = (div_q == twu_pkg::DIV_LAST) & tin_s;
                    twu_pkg::TWU_IN_TRIG:   cnt_en = (div_q == twu_pkg::DIV_LAST) & trig_q;
                    default:                cnt_en = (div_q == twu_pkg::DIV_LAST);
                endcase
            end
        end
    end

    // Prescaler underflow and end of count
    assign ctick   = cnt_en & (psc_q == 8'h00);
    assign eoc     = ctick & (cnt_q == 16'h0000);
    assign wr_lo   = wr_i & (addr_i == twu_pkg::ADDR_CNT_LO);
    assign wr_ctrl = wr_i & (addr_i == twu_pkg::ADDR_CTRL);
    assign retrig  = ~wd_q & ctrl_q.run & ctrl_q.input_en & tin_fall
                   & (ctrl_q.inmd == twu_pkg::TWU_IN_RETRIG);

    // Next-state for counting, registers and outputs
    always_comb
    begin
        ctrl_d      = ctrl_q;
        const_d     = const_q;
        cnt_d       = cnt_q;
        pr_d        = pr_q;
        psc_d       = psc_q;
        div_d       = div_q + 2'h1;
        new_const_d = new_const_q;
        trig_d      = trig_q;
        wd_d        = wd_q;
        watchdog_enable_n_n_d   = watchdog_enable_n_n_q;
        key_d       = key_q;
        strap_d     = (strap_q == 2'b11) ? strap_q : strap_q + 2'h1;
        tlis_d      = tlis_q;
        ia0s_d      = ia0s_q;
        out_d       = out_q;
        srst_d      = 1'b0;
        top_d       = nmi_s;
        a0_d        = external_interrupt_zero_s;
        rdata_d     = 8'h00;

        // Prescaler and counter decrement, reload at end of count
        if (cnt_en)
            psc_d = (psc_q == 8'h00) ? pr_q : psc_q - 8'h01;
        if (ctick)
            cnt_d = eoc ? const_q : cnt_q - 16'h0001;
        if (eoc)
        begin
            new_const_d = 1'b0;
            if (!wd_q && ctrl_q.single)
                ctrl_d.run = 1'b0;
        end

        // Output pin level
        if (!ctrl_q.out_en)
            out_d = 1'b1;
        else if (eoc && !ctrl_q.out_mode)
            out_d = ~out_q;
        else if (eoc)
            out_d = ctrl_q.pwm_level;

        // Interrupt routing; with both selects low only A0 takes the event
        if (!ia0s_q)
            a0_d = eoc & ~wd_q;
        if (!tlis_q)
            top_d = eoc & ~wd_q & ia0s_q;
        srst_d = eoc & wd_q;

        // Trigger arm: falling edge after run, cleared by stop
        if (!ctrl_q.run)
            trig_d = 1'b0;
        else if (tin_fall)
            trig_d = 1'b1;

        // Retrigger restarts from the constant
        if (retrig)
        begin
            cnt_d = const_q;
            psc_d = pr_q;
        end

        // Register writes
        if (wr_i)
        begin
            if (addr_i == twu_pkg::ADDR_CNT_HI)
            begin
                if (!wd_q)
                begin
                    const_d[15:8] = wdata_i;
                    new_const_d   = 1'b1;
                end
            end
            else if (addr_i == twu_pkg::ADDR_CNT_LO)
            begin
                if (!wd_q)
                begin
                    const_d[7:0] = wdata_i;
                    new_const_d  = 1'b1;
                end
                else if (key_q && wdata_i == twu_pkg::KEY_SECOND)
                begin
                    cnt_d = const_q;
                    psc_d = pr_q;
                    key_d = 1'b0;
                end
                else
                    key_d = (wdata_i == twu_pkg::KEY_FIRST);
            end
            else if (addr_i == twu_pkg::ADDR_PSC)
            begin
                pr_d  = wdata_i;
                psc_d = wdata_i;
            end
            else if (addr_i == twu_pkg::ADDR_CTRL)
            begin
                ctrl_d = twu_pkg::twu_ctrl_type'(wdata_i);
                if (wdata_i[7] && !ctrl_q.run && new_const_q)
                begin
                    cnt_d       = const_q;
                    psc_d       = pr_q;
                    new_const_d = 1'b0;
                end
            end
            else if (addr_i == twu_pkg::ADDR_WCR)
            begin
                if (!wdata_i[twu_pkg::WCR_WATCHDOG_ENABLE_N_POS] && watchdog_enable_n_n_q && hwsel_s)
                begin
                    watchdog_enable_n_n_d = 1'b0;
                    wd_d      = 1'b1;
                    cnt_d     = const_q;
                    psc_d     = pr_q;
                end
            end
            else if (addr_i == twu_pkg::ADDR_EIVR)
            begin
                tlis_d = wdata_i[twu_pkg::EIVR_TLIS_POS];
                ia0s_d = wdata_i[twu_pkg::EIVR_IA0S_POS];
            end
        end

        // Strap caught once, after the synchroniser has filled
        if (strap_q == 2'b10 && !hwsel_s)
        begin
            wd_d    = 1'b1;
            const_d = twu_pkg::RST_CNT;
            cnt_d   = twu_pkg::RST_CNT;
            psc_d   = pr_q;
        end

        // Read mux
        if (rd_i)
        begin
            if (addr_i == twu_pkg::ADDR_CNT_HI)
                rdata_d = cnt_q[15:8];
            else if (addr_i == twu_pkg::ADDR_CNT_LO)
                rdata_d = cnt_q[7:0];
            else if (addr_i == twu_pkg::ADDR_PSC)
                rdata_d = pr_q;
            else if (addr_i == twu_pkg::ADDR_CTRL)
                rdata_d = ctrl_q;
            else if (addr_i == twu_pkg::ADDR_WCR)
                rdata_d = 8'(watchdog_enable_n_n_q) << twu_pkg::WCR_WATCHDOG_ENABLE_N_POS;
            else if (addr_i == twu_pkg::ADDR_EIVR)
                rdata_d = (8'(tlis_q) << twu_pkg::EIVR_TLIS_POS)
                        | (8'(ia0s_q) << twu_pkg::EIVR_IA0S_POS);
            else
                rdata_d = 8'h00;
        end
    end

    // State registers
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q      <= twu_pkg::twu_ctrl_type'(twu_pkg::RST_CTRL);
            const_q     <= twu_pkg::RST_CNT;
            cnt_q       <= twu_pkg::RST_CNT;
            pr_q        <= twu_pkg::RST_PSC;
            psc_q       <= twu_pkg::RST_PSC;
            div_q       <= 2'h0;
            new_const_q <= 1'b0;
            trig_q      <= 1'b0;
            wd_q        <= 1'b0;
            watchdog_enable_n_n_q   <= 1'b1;
            key_q       <= 1'b0;
            strap_q     <= 2'h0;
            tlis_q      <= twu_pkg::RST_TLIS;
            ia0s_q      <= twu_pkg::RST_IA0S;
            out_q       <= 1'b1;
            srst_q      <= 1'b0;
            top_q       <= 1'b0;
            a0_q        <= 1'b0;
            rdata_q     <= 8'h00;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            const_q     <= const_d;
            cnt_q       <= cnt_d;
            pr_q        <= pr_d;
            psc_q       <= psc_d;
            div_q       <= div_d;
            new_const_q <= new_const_d;
            trig_q      <= trig_d;
            wd_q        <= wd_d;
            watchdog_enable_n_n_q   <= watchdog_enable_n_n_d;
            key_q       <= key_d;
            strap_q     <= strap_d;
            tlis_q      <= tlis_d;
            ia0s_q      <= ia0s_d;
            out_q       <= out_d;
            srst_q      <= srst_d;
            top_q       <= top_d;
            a0_q        <= a0_d;
            rdata_q     <= rdata_d;
        end
    end

    // Outputs straight from flops
    assign rdata_o            = rdata_q;
    assign timer_output_pin_o = out_q;
    assign sys_reset_o        = srst_q;
    assign top_irq_o          = top_q;
    assign inta0_irq_o        = a0_q;

    // =========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    property p_eoc_zero;
        eoc |-> cnt_q == 16'h0000 && psc_q == 8'h00;
    endproperty
    a_eoc_zero: assert property (p_eoc_zero) else $error("end of count away from zero");

    property p_reload;
        eoc && !wr_i && !retrig |=> cnt_q == $past(const_q);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at end of count");

    property p_single_stop;
        eoc && !wd_q && ctrl_q.single && !wr_ctrl |=> !ctrl_q.run;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single mode kept running");

    property p_stopped_hold;
        !ctrl_q.run && !wd_q && !wr_i && strap_q == 2'b11 |=> $stable(cnt_q);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

    property p_out_off;
        !ctrl_q.out_en |=> timer_output_pin_o;
    endproperty
    a_out_off: assert property (p_out_off) else $error("disabled output not high");

    property p_square;
        eoc && ctrl_q.out_en && !ctrl_q.out_mode |=> timer_output_pin_o != $past(out_q);
    endproperty
    a_square: assert property (p_square) else $error("square output did not toggle");

    property p_pwm;
        eoc && ctrl_q.out_en && ctrl_q.out_mode |=> timer_output_pin_o == $past(ctrl_q.pwm_level);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm level not copied");

    property p_wd_reset;
        wd_q && eoc |=> sys_reset_o ##1 !sys_reset_o;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset pulse wrong");

    property p_wd_sticky;
        !watchdog_enable_n_n_q |=> !watchdog_enable_n_n_q && wd_q;
    endproperty
    a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog mode left");

    property p_key;
        wd_q && key_q && wr_lo && wdata_i == twu_pkg::KEY_SECOND |=> cnt_q == $past(const_q) && !key_q;
    endproperty
    a_key: assert property (p_key) else $error("key did not reload counter");

    property p_gated;
        !wd_q && ctrl_q.input_en && ctrl_q.inmd == twu_pkg::TWU_IN_GATED && !tin_s |-> !cnt_en;
    endproperty
    a_gated: assert property (p_gated) else $error("gated count with pin low");

endmodule

// *** sim/twu_pin_model.sv ***
`timescale 1ns/1ps
// ====================================================================
// Timer input pin driver standing in for the outside world
module twu_pin_model
(
    input  wire logic mclk_i, // Internal clock
    output logic      pin_o   // Timer input pin
);
    // Pin idles high
    initial pin_o = 1'b1;

    // Falling edges never closer than the minimum event spacing
    task automatic edges(input int n, input int gap);
        int g;
        g = (gap < twu_pkg::EVENT_MIN_GAP) ? twu_pkg::EVENT_MIN_GAP : gap;
        repeat (n)
        begin
            @(posedge mclk_i);
            pin_o <= 1'b0;
            repeat (g / 2) @(posedge mclk_i);
            pin_o <= 1'b1;
            repeat (g - g / 2 - 1) @(posedge mclk_i);
        end
    endtask

    // Level held at least eight clocks, so no faster than clock over eight
    task automatic hold(input logic v, input int n);
        @(posedge mclk_i);
        pin_o <= v;
        repeat ((n < 8) ? 7 : n - 1) @(posedge mclk_i);
    endtask
endmodule

// *** sim/twu_top_bench.sv ***
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench for the timer watchdog unit
module twu_top_bench;
    typedef struct {bit w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} twu_row_type;
    logic        mclk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        pin;
    logic        hw_sel;
    logic        external_interrupt_zero;
    logic        nmi;
    logic        tout;
    logic        sysrst;
    logic        top_irq;
    logic        a0_irq;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          a0_hits     = 0;
    int          top_hits    = 0;
    int          rst_hits    = 0;
    int          a_m;
    int          t_m;
    int          r_m;
    int          t;
    logic        v;
    twu_row_type rows [11] = '{
        '{0, 8'hF8, 8'h00, 8'hFF}, '{0, 8'hF9, 8'h00, 8'hFF}, '{0, 8'hFA, 8'h00, 8'hFF},
        '{0, 8'hFB, 8'h00, 8'h12}, '{0, 8'hFC, 8'h00, 8'h40}, '{0, 8'hF6, 8'h00, 8'h06},
        '{0, 8'h00, 8'h00, 8'h00}, '{1, 8'hFA, 8'h3C, 8'h3C}, '{1, 8'hF6, 8'h00, 8'h00},
        '{1, 8'hF6, 8'h06, 8'h06}, '{1, 8'h00, 8'hAA, 8'h00}};

    twu_top i_twu_top (.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_input_pin_i(pin),
        .hw_watchdog_select_pin_i(hw_sel), .external_interrupt_zero_i(external_interrupt_zero), .nmi_i(nmi),
        .timer_output_pin_o(tout), .sys_reset_o(sysrst), .top_irq_o(top_irq),
        .inta0_irq_o(a0_irq));

    twu_pin_model i_twu_pin_model (.mclk_i(mclk), .pin_o(pin));

    // ================================================================
    // Clock, time-zero values and pulse counters
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        {rst_n, wr, rd, external_interrupt_zero, nmi, addr, wdata} = '0;
        hw_sel = 1'b1;
    end

    always @(posedge mclk)
    begin
        a0_hits  <= a0_hits + int'(a0_irq === 1'b1);
        top_hits <= top_hits + int'(top_irq === 1'b1);
        rst_hits <= rst_hits + int'(sysrst === 1'b1);
    end

    // ================================================================
    // Shared tasks
    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic do_reset(input logic hw);
        @(posedge mclk);
        rst_n  <= 1'b0;
        hw_sel <= hw;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string s);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        chk(s, {8'h00, e}, {8'h00, rdata});
    endtask

    // Wait for the next channel A0 pulse, giving cycles waited
    task automatic next_a0(output int n);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (a0_irq !== 1'b1 && n < 3000);
    endtask

    task automatic gap(input int want, input string s);
        next_a0(t);
        next_a0(t);
        chk(s, want[15:0], t[15:0]);
    endtask

    task automatic mark(input int n);
        // Let a routing or run change settle before the counts are taken
        repeat (2) @(posedge mclk);
        a_m = a0_hits;
        t_m = top_hits;
        r_m = rst_hits;
        repeat (n) @(posedge mclk);
    endtask

    // ================================================================
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        complete_run();
    end

    // ================================================================
    // Main sequence
    initial
    begin
        do_reset(1'b1);
        chk("idle output", 16'h0001, {15'h0, tout});
        foreach (rows[i])
        begin
            if (rows[i].w)
                wreg(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e, "register");
        end
        // Pin sources on both request lines
        nmi  <= 1'b1;
        external_interrupt_zero <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("nmi route", 16'h0001, {15'h0, top_irq});
        chk("external_interrupt_zero route", 16'h0001, {15'h0, a0_irq});
        nmi  <= 1'b0;
        external_interrupt_zero <= 1'b0;
        // Continuous internal counting, square output
        wreg(8'hF6, 8'h04);
        wreg(8'hF8, 8'h00);
        wreg(8'hF9, 8'h00);
        wreg(8'hFA, 8'h00);
        wreg(8'hFB, 8'h91);
        gap(4, "minimum period");
        next_a0(t);
        v = tout;
        next_a0(t);
        chk("square output", {15'h0, ~v}, {15'h0, tout});
        wreg(8'hF9, 8'h03);
        gap(16, "new constant period");
        wreg(8'hFA, 8'h01);
        gap(32, "new prescaler period");
        wreg(8'hFA, 8'h00);
        wreg(8'hF9, 8'h00);
        gap(4, "restored period");
        wreg(8'hF6, 8'h02);
        mark(40);
        chk("top level count", 16'h0001, 16'(top_hits - t_m inside {[9:11]}));
        chk("a0 quiet", 16'h0000, 16'(a0_hits - a_m));
        wreg(8'hF6, 8'h00);
        mark(40);
        chk("a0 only", 16'h0001, 16'(a0_hits - a_m inside {[9:11]} && top_hits == t_m));
        wreg(8'hFB, 8'h11);
        mark(40);
        chk("stopped", 16'h0000, 16'(a0_hits - a_m));
        // Single mode with constant changed while stopped
        wreg(8'hF9, 8'h01);
        wreg(8'hFA, 8'hFF);
        wreg(8'hFB, 8'hC1);
        next_a0(t);
        rchk(8'hFB, 8'h41, "run cleared");
        rchk(8'hF9, 8'h01, "reloaded");
        wreg(8'hF9, 8'h05);
        wreg(8'hFB, 8'hC1);
        rchk(8'hF9, 8'h05, "loaded at start");
        // Event counter mode
        wreg(8'hFB, 8'h08);
        wreg(8'hF9, 8'h02);
        wreg(8'hFA, 8'h00);
        wreg(8'hFB, 8'h89);
        mark(0);
        i_twu_pin_model.edges(9, 10);
        repeat (10) @(posedge mclk);
        chk("event count", 16'h0003, 16'(a0_hits - a_m));
        // Gated mode
        wreg(8'hFB, 8'h18);
        wreg(8'hF9, 8'h00);
        i_twu_pin_model.hold(1'b0, 8);
        wreg(8'hFB, 8'h99);
        mark(0);
        i_twu_pin_model.hold(1'b0, 40);
        chk("gate low", 16'h0000, 16'(a0_hits - a_m));
        mark(0);
        i_twu_pin_model.hold(1'b1, 44);
        chk("gate high", 16'h0001, 16'(a0_hits - a_m inside {[9:11]}));
        // Triggerable mode
        wreg(8'hFB, 8'h28);
        wreg(8'hFB, 8'hA9);
        mark(0);
        i_twu_pin_model.hold(1'b1, 40);
        chk("untriggered", 16'h0000, 16'(a0_hits - a_m));
        mark(0);
        i_twu_pin_model.edges(1, 8);
        i_twu_pin_model.hold(1'b1, 40);
        chk("triggered", 16'h0001, 16'(a0_hits - a_m inside {[9:12]}));
        // Retriggerable mode
        wreg(8'hFB, 8'h38);
        wreg(8'hF9, 8'h07);
        wreg(8'hFB, 8'hB9);
        mark(0);
        i_twu_pin_model.edges(10, 20);
        chk("retriggered", 16'h0000, 16'(a0_hits - a_m));
        i_twu_pin_model.hold(1'b1, 40);
        chk("retrigger end", 16'h0001, 16'(a0_hits > a_m));
        // PWM output and disabled output
        wreg(8'hFB, 8'h00);
        wreg(8'hF9, 8'h00);
        wreg(8'hFA, 8'h3F);
        wreg(8'hFB, 8'h85);
        next_a0(t);
        wreg(8'hFB, 8'h87);
        chk("pwm held", 16'h0000, {15'h0, tout});
        next_a0(t);
        chk("pwm copied", 16'h0001, {15'h0, tout});
        wreg(8'hFB, 8'h84);
        next_a0(t);
        chk("output disabled", 16'h0001, {15'h0, tout});
        // Software watchdog
        wreg(8'hFB, 8'h00);
        wreg(8'hF9, 8'h07);
        wreg(8'hFA, 8'h00);
        wreg(8'hFC, 8'h00);
        wreg(8'hFC, 8'h40);
        rchk(8'hFC, 8'h00, "enable sticky");
        mark(0);
        repeat (8)
        begin
            wreg(8'hF9, 8'hAA);
            wreg(8'hF9, 8'h55);
            repeat (4) @(posedge mclk);
        end
        chk("fed watchdog", 16'h0000, 16'(rst_hits - r_m));
        repeat (12) @(posedge mclk);
        wreg(8'hF9, 8'hAA);
        wreg(8'hF9, 8'h12);
        wreg(8'hF9, 8'h55);
        mark(20);
        chk("watchdog reset", 16'h0001, 16'(rst_hits > r_m));
        // Hardware watchdog
        do_reset(1'b0);
        rchk(8'hFC, 8'h40, "enable bit kept");
        repeat (1500) @(posedge mclk);
        rchk(8'hF9, 8'hFE, "hw counting");
        wreg(8'hF9, 8'hAA);
        wreg(8'hF9, 8'h55);
        rchk(8'hF9, 8'hFF, "key reload");
        wreg(8'hF8, 8'h00);
        rchk(8'hF8, 8'hFF, "constant fixed");
        wreg(8'hFA, 8'h00);
        rchk(8'hFA, 8'h00, "prescaler writable");
        complete_run();
    end
endmodule
